// [inc/dmac_map.vh]
`ifndef DMAC_MAP_VH
`define DMAC_MAP_VH
// arithmetic mode select
`define DMAC_MODE_MUL 2'h0
`define DMAC_MODE_SIMD 2'h1
`define DMAC_MODE_LOGIC 2'h2
`define DMAC_MODE_CNT 2'h3
// simd operation select
`define DMAC_OP_ADD 2'h0
`define DMAC_OP_SUB 2'h1
`define DMAC_OP_ACC 2'h2
// simd lane width select
`define DMAC_LANE_ONE 2'h0
`define DMAC_LANE_TWO 2'h1
`define DMAC_LANE_FOUR 2'h2
// xor width select
`define DMAC_XW_12 2'h0
`define DMAC_XW_24 2'h1
`define DMAC_XW_48 2'h2
`define DMAC_XW_96 2'h3
// logic function codes, ten of them
`define DMAC_LF_AND 4'h0
`define DMAC_LF_OR 4'h1
`define DMAC_LF_XOR 4'h2
`define DMAC_LF_NAND 4'h3
`define DMAC_LF_NOR 4'h4
`define DMAC_LF_XNOR 4'h5
`define DMAC_LF_ANDN 4'h6
`define DMAC_LF_ORN 4'h7
`define DMAC_LF_NOTA 4'h8
`define DMAC_LF_PASSA 4'h9
// reset values
`define DMAC_ACC_RST 48'h000000000000
`endif

// [rtl/dmac_pipe_stage.v]
`timescale 1ns/100ps
`default_nettype none
module dmac_pipe_stage #(
  parameter W = 48
) (
  // clock and reset
  input wire i_core_clk,
  input wire i_sys_rst,
  // control
  input wire i_bypass,
  // data
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] q_r;
  // optional register; bypassed stage saves a cycle at the cost of timing
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      q_r <= {W{1'b0}};
    end else begin
      q_r <= i_d;
    end
  end
  assign o_q = i_bypass ? i_d : q_r;
endmodule
`default_nettype wire

// [rtl/dmac_slice.v]
// Notes on behaviour
// - signed 27 by 18 full product
// - 48-bit accumulator adds result when enabled
// - bypass multiplier; simd one, two, four lanes
// - logic unit with ten bitwise functions
// - pre-adder sums two inputs before multiply
// - 96-bit xor parity, 12/24/48/96 groups
// - 48-bit pattern match with rounding support
// - pattern detect over two successive words spans 96
// - accumulator counts up or down
// - optional pipeline registers along datapath
`timescale 1ns/100ps
`default_nettype none
`include "dmac_map.vh"
module dmac_slice (
  // clock and reset
  input wire i_core_clk,
  input wire i_sys_rst,
  // operands
  input wire [26:0] i_a,
  input wire [26:0] i_d,
  input wire [17:0] i_b,
  input wire [47:0] i_x,
  input wire [47:0] i_y,
  // controls
  input wire i_en,
  input wire [1:0] i_mode,
  input wire [1:0] i_simd_op,
  input wire [1:0] i_lane,
  input wire [3:0] i_logic_fn,
  input wire [1:0] i_xor_w,
  input wire i_preadd_en,
  input wire i_preadd_sub,
  input wire i_count_down,
  input wire i_load,
  input wire [47:0] i_load_val,
  input wire i_pipe_in_byp,
  input wire i_pipe_mul_byp,
  // pattern detect configuration
  input wire [47:0] i_pattern,
  input wire [47:0] i_pat_mask,
  // results
  output reg [47:0] o_p,
  output reg o_pat_match,
  output reg o_pat_match_n,
  output reg o_wide_match,
  output reg [7:0] o_xor_par,
  output reg [3:0] o_carry
);
  reg [47:0] acc_r;
  reg [47:0] acc_nxt;
  reg [3:0] carry_nxt;
  reg [47:0] logic_res;
  reg [7:0] xor_nxt;
  reg [47:0] lo_wide_r;
  wire [26:0] a_s;
  wire [26:0] d_s;
  wire [17:0] b_s;
  wire [27:0] pre_sum;
  wire [45:0] prod;
  wire [47:0] prod_s;
  wire [47:0] prod_ext;
  wire [47:0] opnd;
  wire [95:0] xin;
  wire pat_eq;
  wire wide_ok;
  integer k;

  // input stage registers, optional
  dmac_pipe_stage #(.W(27)) u_pa (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_bypass(i_pipe_in_byp), .i_d(i_a), .o_q(a_s));
  dmac_pipe_stage #(.W(27)) u_pd (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_bypass(i_pipe_in_byp), .i_d(i_d), .o_q(d_s));
  dmac_pipe_stage #(.W(18)) u_pb (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_bypass(i_pipe_in_byp), .i_d(i_b), .o_q(b_s));

  // pre-adder keeps one guard bit so d+a never wraps
  assign pre_sum = !i_preadd_en ? {a_s[26], a_s} :
    (i_preadd_sub ? ({d_s[26], d_s} - {a_s[26], a_s}) : ({d_s[26], d_s} + {a_s[26], a_s}));
  assign prod = $signed(pre_sum) * $signed(b_s);
  assign prod_ext = {{2{prod[45]}}, prod};

  dmac_pipe_stage #(.W(48)) u_pm (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst),
    .i_bypass(i_pipe_mul_byp), .i_d(prod_ext), .o_q(prod_s));

  // multiplier bypass selects the wide operand
  assign opnd = (i_mode == `DMAC_MODE_MUL) ? prod_s : i_x;

  // simd lane add/sub; carries cut at lane boundaries
  function [51:0] simd;
    input [47:0] p;
    input [47:0] q;
    input sub;
    input [1:0] lane;
    reg [12:0] s;
    reg c;
    reg [47:0] r;
    reg [3:0] co;
    integer j;
    begin
      c = sub;
      r = 48'h000000000000;
      co = 4'h0;
      for (j = 0; j < 4; j = j + 1) begin
        if ((lane == `DMAC_LANE_FOUR) || (lane == `DMAC_LANE_TWO && (j == 0 || j == 2))) begin
          c = sub;
        end
        s = {1'b0, p[j*12 +: 12]} + {1'b0, (sub ? ~q[j*12 +: 12] : q[j*12 +: 12])} + {12'h000, c};
        r[j*12 +: 12] = s[11:0];
        c = s[12];
        co[j] = s[12];
      end
      simd = {co, r};
    end
  endfunction

  always @* begin
    case (i_logic_fn)
      `DMAC_LF_AND: logic_res = acc_r & i_y;
      `DMAC_LF_OR: logic_res = acc_r | i_y;
      `DMAC_LF_XOR: logic_res = acc_r ^ i_y;
      `DMAC_LF_NAND: logic_res = ~(acc_r & i_y);
      `DMAC_LF_NOR: logic_res = ~(acc_r | i_y);
      `DMAC_LF_XNOR: logic_res = ~(acc_r ^ i_y);
      `DMAC_LF_ANDN: logic_res = acc_r & ~i_y;
      `DMAC_LF_ORN: logic_res = acc_r | ~i_y;
      `DMAC_LF_NOTA: logic_res = ~acc_r;
      `DMAC_LF_PASSA: logic_res = acc_r;
      default: logic_res = 48'h000000000000;
    endcase
  end

  always @* begin
    acc_nxt = acc_r;
    carry_nxt = o_carry;
    if (i_load) begin
      acc_nxt = i_load_val;
    end else if (i_en) begin
      case (i_mode)
        `DMAC_MODE_MUL: begin
          acc_nxt = acc_r + opnd;
        end
        `DMAC_MODE_SIMD: begin
          case (i_simd_op)
            `DMAC_OP_ADD: {carry_nxt, acc_nxt} = simd(opnd, i_y, 1'b0, i_lane);
            `DMAC_OP_SUB: {carry_nxt, acc_nxt} = simd(opnd, i_y, 1'b1, i_lane);
            `DMAC_OP_ACC: {carry_nxt, acc_nxt} = simd(acc_r, opnd, 1'b0, i_lane);
            default: {carry_nxt, acc_nxt} = simd(opnd, i_y, 1'b0, i_lane);
          endcase
        end
        `DMAC_MODE_LOGIC: begin
          acc_nxt = logic_res;
        end
        `DMAC_MODE_CNT: begin
          acc_nxt = i_count_down ? acc_r - 48'h000000000001 : acc_r + 48'h000000000001;
        end
        default: acc_nxt = acc_r;
      endcase
    end
  end

  // 96-bit parity over accumulator and y operand
  assign xin = {i_y, acc_r};
  always @* begin
    xor_nxt = 8'h00;
    for (k = 0; k < 8; k = k + 1) begin
      case (i_xor_w)
        `DMAC_XW_12: xor_nxt[k] = ^xin[k*12 +: 12];
        `DMAC_XW_24: xor_nxt[k] = (k < 4) ? ^xin[k*24 +: 24] : 1'b0;
        `DMAC_XW_48: xor_nxt[k] = (k < 2) ? ^xin[k*48 +: 48] : 1'b0;
        `DMAC_XW_96: xor_nxt[k] = (k == 0) ? ^xin : 1'b0;
        default: xor_nxt[k] = 1'b0;
      endcase
    end
  end

  // masked compare; mask bits set are don't-care, which gives the round-tie test
  assign pat_eq = &(~(acc_r ^ i_pattern) | i_pat_mask);

  // wide match: this cycle's lower half matched last cycle, so two words give 96 bits
  assign wide_ok = pat_eq && (lo_wide_r == 48'hffffffffffff);

  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      acc_r <= `DMAC_ACC_RST;
      o_carry <= 4'h0;
      o_p <= 48'h000000000000;
      o_pat_match <= 1'b0;
      o_pat_match_n <= 1'b0;
      o_wide_match <= 1'b0;
      o_xor_par <= 8'h00;
      lo_wide_r <= 48'h000000000000;
    end else begin
      acc_r <= acc_nxt;
      o_carry <= carry_nxt;
      o_p <= acc_r;
      o_pat_match <= pat_eq;
      o_pat_match_n <= &(~(acc_r ^ ~i_pattern) | i_pat_mask);
      o_wide_match <= wide_ok;
      o_xor_par <= xor_nxt;
      lo_wide_r <= {48{pat_eq}};
    end
  end
endmodule
`default_nettype wire

// [verification/dmac_slice_sva.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dmac_map.vh"
module dmac_slice_chk (
  // clock and reset
  input wire i_core_clk,
  input wire i_sys_rst,
  // operands and controls
  input wire [26:0] i_a,
  input wire [17:0] i_b,
  input wire [47:0] i_x,
  input wire [47:0] i_y,
  input wire i_en,
  input wire i_load,
  input wire [47:0] i_load_val,
  input wire [1:0] i_mode,
  input wire [1:0] i_simd_op,
  input wire [1:0] i_lane,
  input wire [1:0] i_xor_w,
  input wire i_preadd_en,
  input wire i_count_down,
  input wire [47:0] i_pattern,
  input wire [47:0] i_pat_mask,
  // results
  input wire [47:0] o_p,
  input wire o_pat_match,
  input wire [7:0] o_xor_par
);
  wire signed [47:0] prod = $signed(i_a) * $signed(i_b);
  wire go = i_en && !i_load;
  // mul check assumes operands steady across any pipe stage in use
  wire mul = go && i_mode == `DMAC_MODE_MUL && !i_preadd_en;
  wire cnt = go && i_mode == `DMAC_MODE_CNT;
  wire add1 = go && i_mode == `DMAC_MODE_SIMD && i_simd_op == `DMAC_OP_ADD && i_lane == `DMAC_LANE_ONE;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  rst_clear_a: assert property ($past(i_sys_rst) |-> o_p == 48'h0) else $error("o_p not cleared");
  acc_hold_a: assert property ($past(!i_en && !i_load, 2) |-> $stable(o_p)) else $error("o_p moved");
  acc_load_a: assert property ($past(i_load, 2) |-> o_p == $past(i_load_val, 2)) else $error("load");
  mul_acc_a: assert property ($past(mul, 2) |-> o_p == $past(o_p) + $past(prod, 2)) else $error("mac");
  count_step_a: assert property ($past(cnt, 2) |->
    o_p == $past(o_p) + ($past(i_count_down, 2) ? 48'hffffffffffff : 48'h1)) else $error("count");
  simd_add_a: assert property ($past(add1, 2) |-> o_p == $past(i_x, 2) + $past(i_y, 2)) else $error("add");
  pat_hit_a: assert property (o_pat_match ==
    ((o_p & ~$past(i_pat_mask)) == ($past(i_pattern) & ~$past(i_pat_mask)))) else $error("pattern");
  xor_all_a: assert property ($past(i_xor_w) == `DMAC_XW_96 |->
    o_xor_par[0] == ^{$past(i_y), o_p}) else $error("parity");
  cover property ($past(mul, 2));
  cover property ($past(cnt, 2));
  cover property ($past(add1, 2));
endmodule
bind dmac_slice dmac_slice_chk i_chk (.*);
`default_nettype wire

// [verification/dmac_fabric.sv]
`timescale 1ns/100ps
`default_nettype none
module dmac_fabric (
  // clock
  input wire logic i_core_clk,
  // selects: mode, op, lane, logic fn, xor width
  input wire logic [11:0] i_cmd,
  output var logic [11:0] o_sel = 12'h0
);
  // selects move only 1 ns after an edge, so they stay put over the operands
  always @(posedge i_core_clk) #1 o_sel <= i_cmd;
endmodule
`default_nettype wire

// [verification/test_dsp_multiply_accumulate_slice.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dmac_map.vh"
module test_dsp_multiply_accumulate_slice;
  logic clk = 0, rst = 1, en = 0, ld = 0, pe = 0, ps = 0, dn = 0, pib = 1, pmb = 1;
  logic [26:0] a = 0, d = 0;
  logic [17:0] b = 0;
  logic [47:0] x = 0, y = 0, lv = 0, pat = 48'h1, msk = 0;
  logic [11:0] cmd = 0;
  wire [11:0] sel;
  wire [47:0] p;
  wire m, mn, wm;
  wire [7:0] par;
  wire [3:0] cy;
  int err_count = 0, n_checks = 0, cyc = 0, k;
  always #20 clk = ~clk;
  dmac_fabric i_fab (.i_core_clk(clk), .i_cmd(cmd), .o_sel(sel));
  dmac_slice i_dut (.i_core_clk(clk), .i_sys_rst(rst), .i_a(a), .i_d(d), .i_b(b), .i_x(x), .i_y(y),
    .i_en(en), .i_mode(sel[11:10]), .i_simd_op(sel[9:8]), .i_lane(sel[7:6]), .i_logic_fn(sel[5:2]),
    .i_xor_w(sel[1:0]), .i_preadd_en(pe), .i_preadd_sub(ps), .i_count_down(dn), .i_load(ld),
    .i_load_val(lv), .i_pipe_in_byp(pib), .i_pipe_mul_byp(pmb), .i_pattern(pat), .i_pat_mask(msk),
    .o_p(p), .o_pat_match(m), .o_pat_match_n(mn), .o_wide_match(wm), .o_xor_par(par), .o_carry(cy));
  task wrap_up;
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input string nm, input [47:0] ex, input [47:0] got);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  // load v, then one enabled edge if e, then let the result reach o_p
  task run(input [47:0] v, input e);
    @(posedge clk) #1 ld = 1;
    lv = v;
    @(posedge clk) #1 ld = 0;
    en = e;
    @(posedge clk) #1 en = 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  function automatic [47:0] lf(input [3:0] f, input [47:0] q, input [47:0] r);
    case (f)
      `DMAC_LF_AND: lf = q & r;
      `DMAC_LF_OR: lf = q | r;
      `DMAC_LF_XOR: lf = q ^ r;
      `DMAC_LF_NAND: lf = ~(q & r);
      `DMAC_LF_NOR: lf = ~(q | r);
      `DMAC_LF_XNOR: lf = ~(q ^ r);
      `DMAC_LF_ANDN: lf = q & ~r;
      `DMAC_LF_ORN: lf = q | ~r;
      `DMAC_LF_NOTA: lf = ~q;
      `DMAC_LF_PASSA: lf = q;
      default: lf = 48'h000000000000;
    endcase
  endfunction
  // generous ceiling: the sequence needs about 150 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    chk("p_rst", 48'h0, p);
    a = 27'h7fffffd;
    b = 18'h5;
    run(48'h10, 1);
    chk("p_mac", 48'h1, p);
    pe = 1;
    ps = 1;
    d = 27'h7;
    a = 27'h2;
    run(48'h0, 1);
    chk("p_pre", 48'h19, p);
    pe = 0;
    a = 27'h3;
    b = 18'h3ffff;
    pib = 0;
    pmb = 0;
    run(48'h10, 1);
    chk("p_pipe", 48'hd, p);
    pib = 1;
    pmb = 1;
    cmd = {`DMAC_MODE_CNT, 10'h0};
    dn = 1;
    run(48'h0, 1);
    chk("p_down", 48'hffffffffffff, p);
    dn = 0;
    run(48'hffffffffffff, 1);
    chk("p_up", 48'h0, p);
    cmd = {`DMAC_MODE_SIMD, `DMAC_OP_ADD, `DMAC_LANE_ONE, 6'h0};
    x = 48'hffffffffffff;
    y = 48'h2;
    run(48'h0, 1);
    chk("p_add1", 48'h1, p);
    cmd = {`DMAC_MODE_SIMD, `DMAC_OP_ADD, `DMAC_LANE_FOUR, 6'h0};
    x = 48'h001002003fff;
    y = 48'h001001001001;
    run(48'h0, 1);
    chk("p_add4", 48'h002003004000, p);
    chk("cy_add4", 48'h1, {44'h0, cy});
    cmd = {`DMAC_MODE_SIMD, `DMAC_OP_SUB, `DMAC_LANE_TWO, 6'h0};
    x = 48'h000001000000;
    y = 48'h1;
    run(48'h0, 1);
    chk("p_sub2", 48'h000001ffffff, p);
    chk("cy_sub2", 48'hc, {44'h0, cy});
    y = 48'h0f0f0f0f0f0f;
    for (k = 0; k < 11; k++) begin
      cmd = {`DMAC_MODE_LOGIC, 4'h0, k[3:0], 2'h0};
      run(48'h00ff00ff00ff, 1);
      chk("p_logic", lf(k[3:0], 48'h00ff00ff00ff, y), p);
    end
    pat = 48'h123;
    run(48'h123, 0);
    chk("match", 48'h1, {47'h0, m});
    chk("match_n", 48'h0, {47'h0, mn});
    chk("wide", 48'h1, {47'h0, wm});
    run(48'hfffffffffedc, 0);
    chk("match_n", 48'h1, {47'h0, mn});
    chk("match", 48'h0, {47'h0, m});
    cmd = {10'h0, `DMAC_XW_12};
    y = 48'h1;
    run(48'h001000000003, 0);
    chk("par12", 48'h18, {40'h0, par});
    cmd = {10'h0, `DMAC_XW_96};
    run(48'h001000000003, 0);
    chk("par96", 48'h0, {47'h0, par[0]});
    wrap_up;
  end
endmodule
`default_nettype wire
